// ### rtl/ddc_preset_binding_regs.sv
/*
 Configuration registers around the two down-converters: preset selection, channel binding,
 rational divisor and phase-sync arming, reached over an AHB-Lite slave port.
 Each register takes one aligned word at four times its register index: mode, select, binding,
 divisor (whole word), divisor upper byte alias and phase sync, plus a core control word of our own
 holding the per-core power-downs, link and calibration enables and a single-channel flag.
 Writes land at the end of the data phase; read data is captured in the address phase,
 so a read issued in the data phase of a write to the same word still returns the old value.
 Reserved bits are stored and read back as written.
 The datapath, preset words and serial link sit outside and see only the struct outputs.
 Assumes one clock, synchronous active-low reset, and a datapath that consumes the struct outputs.
*/
// The AHB-Lite interface to the registers is this design's own decision.
//
// Function
// - Select field bits 3-2 pick converter B preset
// - Select field bits 1-0 pick converter A preset
// - Bind bit 1 routes core A/B to B
// - Bind bit 0 routes core A/B to A
// - Binding register resets to 0x02
// - Channel powers down when bound core down
// - Sixteen-bit divisor at 0x217, resets zero
// - One divisor corrects error for all presets
// - Phase-sync register resets 0x02, two bits
// - Mode picks register, own pins, or shared
// - Link-start bit inits phase at alignment edge
// - Arm bit 0-then-1 inits on next SYSREF
`include "ddc_preset_cfg.svh"

// Bus port, preset pins, sync inputs and packed result structs
module ddc_preset_binding_regs (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [1:0] preset_pins_conv_a,
   input wire logic [1:0] preset_pins_conv_b,
   input wire logic sysref,
   input wire logic alignStartEdge,
   output ddc_preset_pkg::preset_out_t presetOut,
   output ddc_preset_pkg::bind_out_t bindOut,
   output ddc_preset_pkg::sync_out_t syncOut
);

   // ----------------------------------------
   // Registers and state
   // ----------------------------------------
   // Register storage
   logic [7:0] preset_source_mode;
   logic [7:0] preset_select;
   logic [7:0] channel_binding;
   logic [15:0] rational_ref_divisor;
   logic [7:0] phase_sync_control;
   logic [7:0] coreControl;
   // Bus data-phase tracking
   logic writePending;
   logic [11:0] writeIndex;
   logic accessValid;
   logic [11:0] accessIndex;
   // Synchroniser flops
   logic [1:0] pinsASync1;
   logic [1:0] pinsASync2;
   logic [1:0] pinsBSync1;
   logic [1:0] pinsBSync2;
   logic sysrefSync1;
   logic sysrefSync2;
   logic sysrefLast;
   // Arming, decode and read mux
   logic nextSyncArmed;
   logic armWroteZero;
   logic [1:0] next_indexA;
   logic [1:0] next_indexB;
   logic sysrefRise;
   logic ilaInit;
   logic [31:0] next_hrdata;

   // Word index from a byte address
   function automatic logic [11:0] word_index(input logic [31:0] addr);
      word_index = addr[13:2];
   endfunction

   // Whether an index maps to a register
   function automatic logic is_mapped(input logic [11:0] idx);
      is_mapped = (idx == `PRESET_MODE_IDX) || (idx == `PRESET_SELECT_IDX) ||
         (idx == `CHANNEL_BINDING_IDX) || (idx == `RDIV_IDX) || (idx == `RDIV_HI_IDX) ||
         (idx == `PHASE_SYNC_IDX) || (idx == `CORE_CONTROL_IDX);
   endfunction

   // Power-down state of the core that a channel is bound to
   function automatic logic bound_core_down(input logic coreSel, input logic [7:0] ctrl);
      bound_core_down = coreSel ? ctrl[`PD_B_BIT] : ctrl[`PD_A_BIT];
   endfunction

   // ----------------------------------------
   // Bus slave: zero-wait, always OKAY
   // ----------------------------------------
   // The slave never stalls, so the data phase is always one cycle
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign accessValid = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];
   assign accessIndex = word_index(haddr);

   // Capture the address phase of a write
   // Index is held for the data phase, when hwdata arrives
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         writePending <= 1'b0;
         writeIndex <= 12'h000;
      end else if (hready) begin
         writePending <= accessValid && hwrite && is_mapped(accessIndex);
         writeIndex <= accessIndex;
      end
   end

   // Read data mux, unmapped reads zero
   // Divisor upper byte is also readable alone at its alias
   always_comb begin
      next_hrdata = `ZERO_WORD;
      case (accessIndex)
         `PRESET_MODE_IDX: next_hrdata = {24'h00_0000, preset_source_mode};
         `PRESET_SELECT_IDX: next_hrdata = {24'h00_0000, preset_select};
         `CHANNEL_BINDING_IDX: next_hrdata = {24'h00_0000, channel_binding};
         `RDIV_IDX: next_hrdata = {16'h0000, rational_ref_divisor};
         `RDIV_HI_IDX: next_hrdata = {24'h00_0000, rational_ref_divisor[15:8]};
         `PHASE_SYNC_IDX: next_hrdata = {24'h00_0000, phase_sync_control};
         `CORE_CONTROL_IDX: next_hrdata = {24'h00_0000, coreControl};
         default: next_hrdata = `ZERO_WORD;
      endcase
   end

   // Read data registered at the address phase
   // Captured early so it stands through the whole data phase
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         hrdata <= `ZERO_WORD;
      end else if (accessValid && !hwrite) begin
         hrdata <= next_hrdata;
      end
   end

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   // Reserved bits are kept and read back; software must write them as zero
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         preset_source_mode <= `PRESET_MODE_RST;
         preset_select <= `PRESET_SELECT_RST;
         channel_binding <= `CHANNEL_BINDING_RST;
         coreControl <= `CORE_CONTROL_RST;
      end else if (writePending) begin
         case (writeIndex)
            `PRESET_MODE_IDX: preset_source_mode <= hwdata[7:0];
            `PRESET_SELECT_IDX: preset_select <= hwdata[7:0];
            `CHANNEL_BINDING_IDX: channel_binding <= hwdata[7:0];
            `CORE_CONTROL_IDX: coreControl <= hwdata[7:0];
            default: coreControl <= coreControl;
         endcase
      end
   end

   // Divisor: full word at 0x217, upper byte alone at 0x218
   // A byte write to the alias leaves the low byte as it was
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         rational_ref_divisor <= `RDIV_RST;
      end else if (writePending && writeIndex == `RDIV_IDX) begin
         rational_ref_divisor <= hwdata[15:0];
      end else if (writePending && writeIndex == `RDIV_HI_IDX) begin
         rational_ref_divisor[15:8] <= hwdata[7:0];
      end
   end

   // Phase-sync register
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         phase_sync_control <= `PHASE_SYNC_RST;
      end else if (writePending && writeIndex == `PHASE_SYNC_IDX) begin
         phase_sync_control <= hwdata[7:0];
      end
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Only the second flop of each pair feeds logic; sysrefLast remembers the last level
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         pinsASync1 <= 2'h0;
         pinsASync2 <= 2'h0;
         pinsBSync1 <= 2'h0;
         pinsBSync2 <= 2'h0;
         sysrefSync1 <= 1'b0;
         sysrefSync2 <= 1'b0;
         sysrefLast <= 1'b0;
      end else begin
         pinsASync1 <= preset_pins_conv_a;
         pinsASync2 <= pinsASync1;
         pinsBSync1 <= preset_pins_conv_b;
         pinsBSync2 <= pinsBSync1;
         sysrefSync1 <= sysref;
         sysrefSync2 <= sysrefSync1;
         sysrefLast <= sysrefSync2;
      end
   end

   assign sysrefRise = sysrefSync2 && !sysrefLast;

   // ----------------------------------------
   // Preset source selection
   // ----------------------------------------
   // Pin modes add two edges of latency through the synchronisers
   always_comb begin
      case (preset_source_mode[1:0])
         `MODE_REGISTER: begin
            next_indexA = preset_select[`SEL_A_LSB +: 2];
            next_indexB = preset_select[`SEL_B_LSB +: 2];
         end
         `MODE_PINS_EACH: begin
            next_indexA = pinsASync2;
            next_indexB = pinsBSync2;
         end
         `MODE_PINS_SHARED: begin
            next_indexA = pinsASync2;
            next_indexB = pinsASync2;
         end
         // Reserved mode 3: keep the last choice rather than guess
         default: begin
            next_indexA = presetOut.indexConvA; // Reserved mode holds last choice
            next_indexB = presetOut.indexConvB;
         end
      endcase
   end

   // Registered preset outputs; one divisor for all presets
   // Divisor is copied out unchanged; every preset shares it
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         presetOut <= '0;
      end else begin
         presetOut.indexConvA <= next_indexA;
         presetOut.indexConvB <= next_indexB;
         presetOut.rationalDivisor <= rational_ref_divisor;
      end
   end

   // ----------------------------------------
   // Channel binding and power-down
   // ----------------------------------------
   // Leaves reset at the reset routing: B on core B, nothing powered down
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         bindOut <= `BIND_OUT_RST;
      end else begin
         bindOut.channelASourceSelect <= channel_binding[`BIND_A_BIT];
         bindOut.channelBSourceSelect <= channel_binding[`BIND_B_BIT];
         bindOut.channelAPowerDown <= bound_core_down(channel_binding[`BIND_A_BIT], coreControl);
         bindOut.channelBPowerDown <= bound_core_down(channel_binding[`BIND_B_BIT], coreControl);
         bindOut.linkAPowerDown <= bound_core_down(channel_binding[`BIND_A_BIT], coreControl);
         bindOut.linkBPowerDown <= bound_core_down(channel_binding[`BIND_B_BIT], coreControl);
      end
   end

   // ----------------------------------------
   // Phase initialisation arming
   // ----------------------------------------
   // Link-start init needs no arming: it follows the bit directly
   assign ilaInit = phase_sync_control[`SYNC_ILA_BIT] && alignStartEdge;

   // Arm after 0 then 1; disarm on first SYSREF rise
   // A phase-sync write and a SYSREF rise in one cycle: the write wins
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         armWroteZero <= 1'b0;
         nextSyncArmed <= 1'b0;
      end else if (writePending && writeIndex == `PHASE_SYNC_IDX) begin
         armWroteZero <= !hwdata[`SYNC_NEXT_BIT];
         nextSyncArmed <= hwdata[`SYNC_NEXT_BIT] && armWroteZero;
      end else if (sysrefRise) begin
         nextSyncArmed <= 1'b0;
      end
   end

   // Phase init pulse and status
   // Status leaves reset as the register does, with link-start init on
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         syncOut <= `SYNC_OUT_RST;
      end else begin
         syncOut.linkStartPhaseInit <= phase_sync_control[`SYNC_ILA_BIT];
         syncOut.nextSyncArmed <= nextSyncArmed;
         syncOut.phaseInitPulse <= ilaInit || (nextSyncArmed && sysrefRise);
      end
   end

endmodule

// ### rtl/ddc_preset_cfg.svh
/*
 Register offsets, reset values and field positions for the down-converter preset and binding registers.
 Assumes an AHB-Lite slave with one register per aligned 32-bit word.
*/
`ifndef DDC_PRESET_CFG_SVH
`define DDC_PRESET_CFG_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define PRESET_MODE_IDX 12'h0214
`define PRESET_SELECT_IDX 12'h0215
`define CHANNEL_BINDING_IDX 12'h0216
`define RDIV_IDX 12'h0217
`define RDIV_HI_IDX 12'h0218
`define PHASE_SYNC_IDX 12'h0219
`define CORE_CONTROL_IDX 12'h0220
`define ADDR_OF(idx) {(idx), 2'b00}

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PRESET_MODE_RST 8'h00
`define PRESET_SELECT_RST 8'h00
`define CHANNEL_BINDING_RST 8'h02
`define RDIV_RST 16'h0000
`define PHASE_SYNC_RST 8'h02
`define CORE_CONTROL_RST 8'h00
`define BIND_OUT_RST 6'h10
`define SYNC_OUT_RST 3'h4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SEL_A_LSB 0
`define SEL_B_LSB 2
`define BIND_A_BIT 0
`define BIND_B_BIT 1
`define SYNC_NEXT_BIT 0
`define SYNC_ILA_BIT 1
`define PD_A_BIT 0
`define PD_B_BIT 1
`define LINK_EN_BIT 2
`define CAL_EN_BIT 3
`define SINGLE_CH_BIT 4

// ----------------------------------------
// Preset source modes
// ----------------------------------------
`define MODE_REGISTER 2'h0
`define MODE_PINS_EACH 2'h1
`define MODE_PINS_SHARED 2'h2

// ----------------------------------------
// Bus encodings
// ----------------------------------------
`define HTRANS_NONSEQ_BIT 1
`define ZERO_WORD 32'h0000_0000
`endif

// ### rtl/ddc_preset_pkg.sv
/*
 Types shared by the preset and binding register block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ddc_preset_pkg;
   // Per-converter preset choice and correction divisor
   typedef struct packed {
      logic [1:0] indexConvA;
      logic [1:0] indexConvB;
      logic [15:0] rationalDivisor;
   } preset_out_t;

   // Channel routing and power state
   typedef struct packed {
      logic channelASourceSelect;
      logic channelBSourceSelect;
      logic channelAPowerDown;
      logic channelBPowerDown;
      logic linkAPowerDown;
      logic linkBPowerDown;
   } bind_out_t;

   // Oscillator phase initialisation controls
   typedef struct packed {
      logic linkStartPhaseInit;
      logic nextSyncArmed;
      logic phaseInitPulse;
   } sync_out_t;
endpackage

// ### verification/ddc_preset_binding_regs_monitor.sv
/*
 Checker for the preset and binding register block.
 Assumes a bind to the top module; sees only its ports.
*/
`include "ddc_preset_cfg.svh"
module ddc_preset_binding_regs_monitor (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic alignStartEdge,
   input wire ddc_preset_pkg::preset_out_t presetOut,
   input wire ddc_preset_pkg::bind_out_t bindOut,
   input wire ddc_preset_pkg::sync_out_t syncOut
);
   logic wrPend;
   logic [13:0] wrAddr;
   logic [1:0] mode;
   logic ila;
   wire logic take = hsel && hready && htrans[1];
   // -----------------------------------
   // Data phase tracking and mode copy
   // -----------------------------------
   always_ff @(posedge sys_clk) begin
      wrAddr <= haddr[13:0];
      if (!reset_n) begin
         wrPend <= 1'b0;
         mode <= 2'h0;
         ila <= 1'b1;
      end else begin
         wrPend <= take && hwrite;
         if (wrPend && wrAddr == `ADDR_OF(`PRESET_MODE_IDX)) begin
            mode <= hwdata[1:0];
         end
         if (wrPend && wrAddr == `ADDR_OF(`PHASE_SYNC_IDX)) begin
            ila <= hwdata[`SYNC_ILA_BIT];
         end
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
   a_rst_bind: assert property ($rose(reset_n) |-> bindOut.channelBSourceSelect &&
      !bindOut.channelASourceSelect) else $error("binding reset wrong");
   a_rst_sync: assert property ($rose(reset_n) |-> syncOut.linkStartPhaseInit &&
      !syncOut.nextSyncArmed) else $error("phase sync reset wrong");
   a_ila_pulse: assert property (alignStartEdge && ila |=>
      syncOut.phaseInitPulse) else $error("no phase init at alignment edge");
   a_pulse_single: assert property (syncOut.phaseInitPulse |=> !syncOut.phaseInitPulse)
      else $error("phase init pulse too long");
   a_rdata_hold: assert property (!(take && !hwrite) |=> $stable(hrdata)) else $error("read data moved");
   a_div_write: assert property (wrPend && wrAddr == `ADDR_OF(`RDIV_IDX) |-> ##2
      presetOut.rationalDivisor == $past(hwdata[15:0], 2)) else $error("divisor not applied");
   a_bind_write: assert property (wrPend && wrAddr == `ADDR_OF(`CHANNEL_BINDING_IDX) |-> ##2
      {bindOut.channelBSourceSelect, bindOut.channelASourceSelect} == $past(hwdata[1:0], 2))
      else $error("binding not applied");
   a_sel_write: assert property (wrPend && wrAddr == `ADDR_OF(`PRESET_SELECT_IDX) &&
      mode == `MODE_REGISTER |-> ##2 {presetOut.indexConvB, presetOut.indexConvA} == $past(hwdata[3:0], 2))
      else $error("preset select not applied");
   c_div: cover property (wrPend && wrAddr == `ADDR_OF(`RDIV_IDX));
   c_pulse: cover property (syncOut.phaseInitPulse);
   c_read: cover property (take && !hwrite);
endmodule
bind ddc_preset_binding_regs ddc_preset_binding_regs_monitor i_mon (.sys_clk, .reset_n, .hsel, .haddr,
   .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .alignStartEdge, .presetOut, .bindOut,
   .syncOut);

// ### verification/ddc_preset_binding_regs_tb.sv
/*
 Self-checking bench for the preset and binding register block.
 Assumes the design files and the checker are compiled before it.
*/
`include "ddc_preset_cfg.svh"
module ddc_preset_binding_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int aMode = `ADDR_OF(`PRESET_MODE_IDX);
   localparam int aSel = `ADDR_OF(`PRESET_SELECT_IDX);
   localparam int aBind = `ADDR_OF(`CHANNEL_BINDING_IDX);
   localparam int aDiv = `ADDR_OF(`RDIV_IDX);
   localparam int aSync = `ADDR_OF(`PHASE_SYNC_IDX);
   localparam int aCore = `ADDR_OF(`CORE_CONTROL_IDX);
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [1:0] presetPinsConvA = 2'h0;
   logic [1:0] presetPinsConvB = 2'h0;
   logic sysref = 1'b0;
   logic alignStartEdge = 1'b0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   ddc_preset_pkg::preset_out_t presetOut;
   ddc_preset_pkg::bind_out_t bindOut;
   ddc_preset_pkg::sync_out_t syncOut;
   logic [31:0] seed = 32'h0d3f_bfed;
   int mdl[int];
   int failures = 0;
   int checks = 0;
   int pulses = 0;
   int lastA = 0;
   int lastB = 0;
   ddc_preset_binding_regs i_dut (.sys_clk, .reset_n, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .preset_pins_conv_a(presetPinsConvA),
      .preset_pins_conv_b(presetPinsConvB), .sysref, .alignStartEdge, .presetOut, .bindOut, .syncOut);
   // Clock
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   // Counts phase initialisation pulses
   always @(posedge sys_clk) begin
      if (syncOut.phaseInitPulse === 1'b1) pulses++;
   end
   // --------------------
   // Tasks
   // --------------------
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h0040_0007 : 32'h0000_0000);
      return seed;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("failures %0d checks %0d", failures, checks);
      if (failures == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic bus(input int a, input logic w, input int d, output logic [31:0] q);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      q = hrdata;
   endtask
   task automatic wr(input int a, input int d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
      if (mdl.exists(a)) mdl[a] = d & (a == aDiv ? 'hffff : 'hff);
   endtask
   task automatic rd(input int a);
      logic [31:0] q;
      bus(a, 1'b0, 0, q);
      check(q, mdl.exists(a) ? mdl[a] : 0);
   endtask
   task automatic align();
      alignStartEdge <= 1'b1;
      @(posedge sys_clk);
      alignStartEdge <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic chk_out();
      int m, s, b, c;
      m = mdl[aMode] & 3;
      s = mdl[aSel];
      b = mdl[aBind];
      c = mdl[aCore];
      repeat (5) @(posedge sys_clk);
      if (m == 0) begin
         lastA = s & 3;
         lastB = s >> 2 & 3;
      end else if (m != 3) begin
         lastA = presetPinsConvA;
         lastB = m == 1 ? presetPinsConvB : presetPinsConvA;
      end
      check(presetOut.indexConvA, lastA);
      check(presetOut.indexConvB, lastB);
      check(presetOut.rationalDivisor, mdl[aDiv]);
      check({bindOut.channelBSourceSelect, bindOut.channelASourceSelect}, b & 3);
      check({bindOut.channelAPowerDown, bindOut.linkAPowerDown}, 3 * (c >> (b & 1) & 1));
      check({bindOut.channelBPowerDown, bindOut.linkBPowerDown}, 3 * (c >> (b >> 1 & 1) & 1));
   endtask
   // --------------------
   // Main sequence
   // --------------------
   initial begin
      mdl[aMode] = `PRESET_MODE_RST;
      mdl[aSel] = `PRESET_SELECT_RST;
      mdl[aBind] = `CHANNEL_BINDING_RST;
      mdl[aDiv] = `RDIV_RST;
      mdl[aSync] = `PHASE_SYNC_RST;
      mdl[aCore] = `CORE_CONTROL_RST;
      repeat (16) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      foreach (mdl[a]) rd(a);
      wr('h900, 'hff);
      rd('h900);
      for (int i = 0; i < 12; i++) begin
         presetPinsConvA <= 2'(rnd());
         presetPinsConvB <= 2'(rnd());
         wr(aMode, rnd() % 3);
         wr(aSel, rnd() & 'hf);
         wr(aCore, rnd() & 'h03);
         wr(aBind, rnd() & 'h3);
         wr(aDiv, rnd());
         chk_out();
         foreach (mdl[a]) if (a != aSync) rd(a);
      end
      wr(aMode, 3);
      wr(aSel, rnd() & 'hf);
      presetPinsConvA <= ~presetPinsConvA;
      chk_out();
      align();
      check(pulses, 1);
      check(syncOut.linkStartPhaseInit, 1);
      wr(aSync, 0);
      align();
      check(pulses, 1);
      check(syncOut.linkStartPhaseInit, 0);
      wr(aSync, 1);
      repeat (2) @(posedge sys_clk);
      check(syncOut.nextSyncArmed, 1);
      sysref <= 1'b1;
      repeat (6) @(posedge sys_clk);
      check(pulses, 2);
      check(syncOut.nextSyncArmed, 0);
      sysref <= 1'b0;
      repeat (4) @(posedge sys_clk);
      sysref <= 1'b1;
      repeat (6) @(posedge sys_clk);
      check(pulses, 2);
      give_verdict();
   end
   // Watchdog
   initial begin
      #100000;
      failures++;
      give_verdict();
   end
endmodule
